// >>> core/eoc_pkg.sv
// Package for the external oscillator control block
package eoc_pkg;
    localparam logic [7:0] EOC_CTRL_ADDR   = 8'hb1;
    localparam logic [7:0] EOC_CTRL_RESET  = 8'h00;
    localparam int         EOC_VALID_BIT   = 7;
    localparam int         EOC_MODE_LSB    = 4;
    localparam int         EOC_FREQ_LSB    = 0;
    // Cycles the running indication must hold before valid is reported
    localparam int         EOC_STABLE_CYC  = 16;

    typedef enum logic [2:0] {
        EOC_OFF0   = 3'h0,
        EOC_OFF1   = 3'h1,
        EOC_CMOS   = 3'h2,
        EOC_CMOS2  = 3'h3,
        EOC_RC2    = 3'h4,
        EOC_CAP2   = 3'h5,
        EOC_XTAL   = 3'h6,
        EOC_CRYSTAL_PIN_OUT  = 3'h7
    } eoc_mode_e;

    // Analog drive controls sent to the oscillator pad circuit
    typedef struct packed {
        logic       enable;
        logic       use_crystal_pin_in;
        logic       use_crystal_pin_out;
        logic       divide_by_2;
        logic [2:0] freq_range;
    } eoc_drive_s;
endpackage

// >>> core/eoc_ctrl.sv
// External oscillator control register, mode decode, valid flag, divider
`timescale 1ns/1ps
module eoc_ctrl
    import eoc_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_RD,
    input  wire logic       OSC_RUNNING,
    input  wire logic       OSC_CLK_IN,
    output logic [7:0]      SFR_RDATA,
    output logic            SFR_RHIT,
    output eoc_drive_s      DRIVE,
    output logic            DERIVED_CLK
);
    logic [2:0] mode;
    logic [2:0] freq;
    logic [2:0] next_mode;
    logic [2:0] next_freq;
    logic       run_s1;
    logic       run_s2;
    logic       clk_s1;
    logic       clk_s2;
    logic       clk_s3;
    logic [4:0] stable_cnt;
    logic [4:0] next_stable_cnt;
    logic       valid;
    logic       next_valid;
    logic       half;
    logic       next_half;
    logic [7:0] next_rdata;
    logic       next_rhit;
    eoc_drive_s next_drive;
    logic       next_dclk;

    function automatic logic mode_is_off(input logic [2:0] m);
        return m[2:1] == 2'b00;
    endfunction

    function automatic logic mode_is_cmos(input logic [2:0] m);
        return m[2:1] == 2'b01;
    endfunction

    // Register write decode, any page
    always_comb
    begin
        next_mode = mode;
        next_freq = freq;
        if (SFR_WR && SFR_ADDR == EOC_CTRL_ADDR)
        begin
            next_mode = SFR_WDATA[EOC_MODE_LSB +: 3];
            next_freq = SFR_WDATA[EOC_FREQ_LSB +: 3];
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            mode <= EOC_CTRL_RESET[EOC_MODE_LSB +: 3];
            freq <= EOC_CTRL_RESET[EOC_FREQ_LSB +: 3];
        end
        else
        begin
            mode <= next_mode;
            freq <= next_freq;
        end
    end

    // Pin-side inputs cross into CLK through two flops
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            run_s1 <= 1'b0;
            run_s2 <= 1'b0;
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
        end
        else
        begin
            run_s1 <= OSC_RUNNING;
            run_s2 <= run_s1;
            clk_s1 <= OSC_CLK_IN;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
        end
    end

    // Stability filter and valid flag
    always_comb
    begin
        next_stable_cnt = stable_cnt;
        next_valid      = valid;
        if (mode_is_off(mode) || mode_is_cmos(mode) || !run_s2)
        begin
            next_stable_cnt = 5'h00;
            next_valid      = 1'b0;
        end
        else if (stable_cnt == 5'(EOC_STABLE_CYC))
            next_valid = 1'b1;
        else
            next_stable_cnt = stable_cnt + 5'h01;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            stable_cnt <= 5'h00;
            valid      <= 1'b0;
        end
        else
        begin
            stable_cnt <= next_stable_cnt;
            valid      <= next_valid;
        end
    end

    // Halving stage toggles on each rising oscillator edge
    always_comb
    begin
        next_half = half;
        if (mode_is_off(mode))
            next_half = 1'b0;
        else if (clk_s2 && !clk_s3)
            next_half = ~half;
    end

    // Outputs: read data, pad drive, derived clock
    always_comb
    begin
        next_rhit  = SFR_RD && SFR_ADDR == EOC_CTRL_ADDR;
        next_rdata = 8'h00;
        if (next_rhit)
        begin
            next_rdata[EOC_VALID_BIT]        = valid;
            next_rdata[EOC_MODE_LSB +: 3]    = mode;
            next_rdata[EOC_FREQ_LSB +: 3]    = freq;
        end
        next_drive.enable              = !mode_is_off(mode);
        next_drive.use_crystal_pin_in  = mode[2:1] == 2'b11;
        next_drive.use_crystal_pin_out = !mode_is_off(mode);
        next_drive.divide_by_2 = mode == EOC_CMOS2 || mode == EOC_RC2
                              || mode == EOC_CAP2 || mode == EOC_CRYSTAL_PIN_OUT;
        next_drive.freq_range  = freq;
        if (mode_is_off(mode))
            next_dclk = 1'b0;
        else if (next_drive.divide_by_2)
            next_dclk = half;
        else
            next_dclk = clk_s2;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            half        <= 1'b0;
            SFR_RDATA   <= 8'h00;
            SFR_RHIT    <= 1'b0;
            DRIVE       <= '0;
            DERIVED_CLK <= 1'b0;
        end
        else
        begin
            half        <= next_half;
            SFR_RDATA   <= next_rdata;
            SFR_RHIT    <= next_rhit;
            DRIVE       <= next_drive;
            DERIVED_CLK <= next_dclk;
        end
    end

    // Valid never set in CMOS or off modes
    a_valid_cmos_zero: assert property (@(posedge CLK)
        disable iff (RST)
        (mode_is_cmos(mode) || mode_is_off(mode)) |=> !valid)
        else $error("valid set in CMOS or off mode");
    // Mode going off clears valid next cycle
    a_valid_off_clear: assert property (@(posedge CLK)
        disable iff (RST)
        (valid && mode_is_off(next_mode)) |=> ##1 !valid)
        else $error("valid not cleared after mode off");
    // Register write lands in readback
    a_write_readback: assert property (@(posedge CLK)
        disable iff (RST)
        (SFR_WR && SFR_ADDR == EOC_CTRL_ADDR)
        |=> mode == $past(SFR_WDATA[6:4]) && freq == $past(SFR_WDATA[2:0]))
        else $error("control write not stored");
    // Bit 3 always reads zero
    a_bit3_zero: assert property (@(posedge CLK)
        disable iff (RST)
        !SFR_RDATA[3])
        else $error("unused bit read nonzero");
    // Valid needs stable running in an oscillator mode the cycle before
    a_valid_needs_run: assert property (@(posedge CLK)
        disable iff (RST)
        $rose(valid) |-> $past(run_s2) && $past(mode[2]))
        else $error("valid rose without stable oscillator");
    // Crystal pin in only in crystal modes
    a_xtal_pins: assert property (@(posedge CLK)
        disable iff (RST)
        ##1 DRIVE.use_crystal_pin_in == ($past(mode[2:1]) == 2'b11))
        else $error("crystal pin use wrong");
    // Halved modes 011, 100, 101 and 111 set the divider flag
    a_div_flag: assert property (@(posedge CLK)
        disable iff (RST)
        ##1 DRIVE.divide_by_2 == ($past(mode) inside {3'h3, 3'h4, 3'h5, 3'h7}))
        else $error("divide flag wrong");
    // Unmapped read returns zero, no hit
    a_read_decode: assert property (@(posedge CLK)
        disable iff (RST)
        (SFR_RD && SFR_ADDR != EOC_CTRL_ADDR)
        |=> !SFR_RHIT && SFR_RDATA == 8'h00)
        else $error("read decode wrong");
endmodule // eoc_ctrl

// >>> bench/eoc_osc_model.sv
// Behavioural external oscillator seen from the pad side
`timescale 1ns/1ps
module eoc_osc_model
(
    input  wire logic en,
    output logic      running,
    output logic      osc_clk
);
    // Uneven duty so only a halving stage gives an even one
    initial
    begin
        osc_clk = 1'b0;
        forever
        begin
            if (en)
            begin
                osc_clk = 1'b1;
                #15;
                osc_clk = 1'b0;
                #25;
            end
            else
                #5; // Clock stands still when off
        end
    end
    // Running shows a while after enable, drops at once
    initial
    begin
        running = 1'b0;
        forever
        begin
            @(en);
            running = 1'b0;
            if (en)
                #100 running = en;
        end
    end
endmodule // eoc_osc_model

// >>> bench/testbench.sv
// Self-checking bench for the external oscillator control
`timescale 1ns/1ps
module testbench;
    import eoc_pkg::*;
    logic       CLK = 0, RST = 1, WR = 0, RD = 0, rd_q = 0;
    logic [7:0] ADDR = 0, WDATA = 0, RDATA;
    logic       RHIT, DCLK, RUN, OCLK, div;
    eoc_drive_s DRIVE;
    logic [2:0] m, fr;
    logic [8:0] ex, expq[$];
    int         mismatches = 0, checks = 0, seed = 75625, h;
    eoc_ctrl i_dut (.CLK(CLK), .RST(RST), .SFR_ADDR(ADDR), .SFR_WR(WR),
        .SFR_WDATA(WDATA), .SFR_RD(RD), .OSC_RUNNING(RUN),
        .OSC_CLK_IN(OCLK), .SFR_RDATA(RDATA), .SFR_RHIT(RHIT),
        .DRIVE(DRIVE), .DERIVED_CLK(DCLK));
    eoc_osc_model i_osc (.en(DRIVE.enable), .running(RUN), .osc_clk(OCLK));
    // 200 MHz clock
    initial
        forever #2.5 CLK = ~CLK;
    task automatic chk(input string n, input logic [8:0] e, g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge CLK);
        WR <= 1'b1; ADDR <= a; WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        @(posedge CLK);
        RD <= 1'b1; ADDR <= a; expq.push_back(e);
        @(posedge CLK);
        RD <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Read results: compare with the oldest note one cycle after a read
    always @(negedge CLK)
    begin
        if (rd_q)
            chk("read", expq.pop_front(), {RHIT, RDATA});
        rd_q = RD;
    end
    // Watchdog
    initial
    begin
        #50000 mismatches++;
        give_verdict();
    end
    // Main sequence; software keeps pins, range and start-up order
    initial
    begin
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        rd(EOC_CTRL_ADDR, 9'h100);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            m = i[2:0]; // Each of the eight modes in turn: off, CMOS, RC, cap, crystal
            fr = 3'($random(seed)); // Random range code per mode
            div = (m == 3) || (m == 4) || (m == 5) || (m == 7);
            wr(EOC_CTRL_ADDR, {1'b1, m, 1'b1, fr});
            rd(EOC_CTRL_ADDR, {2'b10, m, 1'b0, fr});
            ex = {5'h0, m >= 2, m >= 6, m >= 2, div};
            #1 chk("drive", ex, 9'(DRIVE[6:3]));
            if (m >= 2)
                chk("range", {6'h0, fr}, {6'h0, DRIVE.freq_range});
            repeat (40) @(posedge CLK); // Shortened settle wait
            h = 0;
            repeat (64)
            begin
                @(posedge CLK);
                #1 h += (DCLK === 1'b1);
            end
            if (div)
                chk("duty", 9'h1, 9'((h >= 30) && (h <= 34)));
            if (m < 2)
                chk("off clock", 9'h0, 9'(h));
            // Unhalved: 15 ns high of 40 ns gives 3 of 8 samples high
            if (m == 2 || m == 6)
                chk("plain clock", 9'h018, 9'(h));
            rd(EOC_CTRL_ADDR, {1'b1, m >= 4, m, 1'b0, fr});
            wr(EOC_CTRL_ADDR, {4'h0, 1'b1, fr});
            repeat (3) @(posedge CLK);
            rd(EOC_CTRL_ADDR, {6'h20, fr});
            $display("test mode %0d done", m);
        end
        wr(8'hb0, 8'h7f);
        rd(8'hb0, 9'h000);
        rd(EOC_CTRL_ADDR, {6'h20, fr});
        @(posedge CLK);
        $display("test unmapped done");
        // Mid-run reset returns the register and pad drive to zero
        wr(EOC_CTRL_ADDR, 8'h67);
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        rd(EOC_CTRL_ADDR, 9'h100);
        #1 chk("reset drive", 9'h000, 9'(DRIVE));
        $display("test mid reset done");
        @(posedge CLK);
        give_verdict();
    end
endmodule // testbench
